/* File: issq_consts.vh */
// Constants for the instrument status and event queue block.
// Assumes a single 10 MHz clock and a command port driven by the message layer.
`ifndef ISSQ_CONSTS_VH
`define ISSQ_CONSTS_VH

// Command codes on cmd_code
`define ISSQ_CMD_STD_EVT_RD   5'h00
`define ISSQ_CMD_STD_ENA_WR   5'h01
`define ISSQ_CMD_STD_ENA_RD   5'h02
`define ISSQ_CMD_OP_COND_RD   5'h03
`define ISSQ_CMD_OP_EVT_RD    5'h04
`define ISSQ_CMD_OP_ENA_WR    5'h05
`define ISSQ_CMD_OP_ENA_RD    5'h06
`define ISSQ_CMD_MS_COND_RD   5'h07
`define ISSQ_CMD_MS_EVT_RD    5'h08
`define ISSQ_CMD_MS_ENA_WR    5'h09
`define ISSQ_CMD_MS_ENA_RD    5'h0a
`define ISSQ_CMD_QS_COND_RD   5'h0b
`define ISSQ_CMD_QS_EVT_RD    5'h0c
`define ISSQ_CMD_QS_ENA_WR    5'h0d
`define ISSQ_CMD_QS_ENA_RD    5'h0e
`define ISSQ_CMD_CLS          5'h0f
`define ISSQ_CMD_PRESET       5'h10
`define ISSQ_CMD_EQ_NEXT      5'h11
`define ISSQ_CMD_EQ_CLEAR     5'h12
`define ISSQ_CMD_FLT_ENA_NEW  5'h13
`define ISSQ_CMD_FLT_ENA_ADD  5'h14
`define ISSQ_CMD_FLT_DIS_ADD  5'h15

// Questionable bit positions and used-bit mask, and the operation idle bit position
`define ISSQ_QS_TEMP_BIT      4
`define ISSQ_QS_CAL_BIT       8
`define ISSQ_QS_WARN_BIT      14
`define ISSQ_QS_USED_MASK     16'h4110
`define ISSQ_OP_IDLE_BIT      10

// Reset values
`define ISSQ_EVT_RST          16'h0000
`define ISSQ_ENA_RST          16'h0000

// Queues and error code filter slots
`define ISSQ_EQ_DEPTH         10
`define ISSQ_EQ_CNT_W         4
`define ISSQ_EQ_OVF_CODE      16'h015e
`define ISSQ_EQ_EMPTY_CODE    16'h0000
`define ISSQ_OQ_DEPTH         4
`define ISSQ_OQ_CNT_W         3
`define ISSQ_FLT_SLOTS        4
`define ISSQ_FLT_IDX_W        3

`endif

/* File: issq_status.v */
// Status structure: condition, event and enable register sets, output queue,
// error queue with code filter. Assumes commands arrive one per accepted
// cycle from a message layer on the same clock; event inputs are same-clock.
`timescale 1ns/1ns
`include "issq_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module issq_evt_set #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] set_bits,
  input  wire         rd_clr,
  input  wire         cls,
  input  wire [W-1:0] ena,
  output reg  [W-1:0] evt_r,
  output wire         summary
);
  reg [W-1:0] evt_nxt;

  // Set wins over a clear in the same cycle
  always @* begin
    evt_nxt = evt_r;
    if (rd_clr || cls) begin
      evt_nxt = {W{1'b0}};
    end
    evt_nxt = evt_nxt | set_bits;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= {W{1'b0}};
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign summary = |(evt_r & ena);
endmodule // issq_evt_set

////////////////////////////////////////////////////////////////////////////////
module issq_status (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [4:0]  cmd_code,
  input  wire [15:0] cmd_data,
  input  wire [15:0] cmd_data_hi,
  input  wire        talk,
  output reg  [15:0] talk_data_r,
  output reg         talk_valid_r,
  input  wire [7:0]  std_evt_set,
  input  wire [15:0] op_cond_in,
  input  wire        instr_idle,
  input  wire [15:0] ms_cond_in,
  input  wire        tc_ref_invalid,
  input  wire        cal_const_bad,
  input  wire        cal_success,
  input  wire        meas_param_ignored,
  input  wire        err_push,
  input  wire [15:0] err_code,
  input  wire        err_is_status,
  output wire        std_summary,
  output wire        op_summary,
  output wire        ms_summary,
  output wire        qs_summary,
  output wire        mav,
  output wire        eav,
  output wire        err_led,
  output wire        use_default_cal
);

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire        cmd_go = cmd_valid & cmd_ready;
  wire        oq_full;
  wire        is_cls    = cmd_go && (cmd_code == `ISSQ_CMD_CLS);
  wire        is_preset = cmd_go && (cmd_code == `ISSQ_CMD_PRESET);
  wire        is_eqnext = cmd_go && (cmd_code == `ISSQ_CMD_EQ_NEXT);
  wire        is_eqclr  = cmd_go && (cmd_code == `ISSQ_CMD_EQ_CLEAR);
  wire        rd_std    = cmd_go && (cmd_code == `ISSQ_CMD_STD_EVT_RD);
  wire        rd_op     = cmd_go && (cmd_code == `ISSQ_CMD_OP_EVT_RD);
  wire        rd_ms     = cmd_go && (cmd_code == `ISSQ_CMD_MS_EVT_RD);
  wire        rd_qs     = cmd_go && (cmd_code == `ISSQ_CMD_QS_EVT_RD);

  // A query needs room for its answer, so commands wait while the output queue is full
  assign cmd_ready = ~oq_full;

  //////////////////////////////////////////////////////////////////////////////
  // Enable registers
  reg [7:0]  std_ena_r;
  reg [15:0] op_ena_r;
  reg [15:0] ms_ena_r;
  reg [15:0] qs_ena_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      std_ena_r <= 8'h00;
      op_ena_r  <= `ISSQ_ENA_RST;
      ms_ena_r  <= `ISSQ_ENA_RST;
      qs_ena_r  <= `ISSQ_ENA_RST;
    end else if (is_preset) begin
      std_ena_r <= 8'h00;
      op_ena_r  <= `ISSQ_ENA_RST;
      ms_ena_r  <= `ISSQ_ENA_RST;
      qs_ena_r  <= `ISSQ_ENA_RST;
    end else if (cmd_go) begin
      case (cmd_code)
        `ISSQ_CMD_STD_ENA_WR: std_ena_r <= cmd_data[7:0];
        `ISSQ_CMD_OP_ENA_WR:  op_ena_r  <= cmd_data;
        `ISSQ_CMD_MS_ENA_WR:  ms_ena_r  <= cmd_data;
        `ISSQ_CMD_QS_ENA_WR:  qs_ena_r  <= cmd_data & `ISSQ_QS_USED_MASK;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition registers
  reg         cal_bad_r;
  reg  [15:0] op_cond_r;
  reg  [15:0] ms_cond_r;
  reg  [15:0] qs_cond_r;
  wire [15:0] op_cond_nxt;
  wire [15:0] qs_cond_nxt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_bad_r <= 1'b0;
    end else if (cal_const_bad) begin
      cal_bad_r <= 1'b1;
    end else if (cal_success) begin
      cal_bad_r <= 1'b0;
    end
  end

  assign use_default_cal = cal_bad_r;

  assign op_cond_nxt = {op_cond_in[15:`ISSQ_OP_IDLE_BIT+1], instr_idle,
                        op_cond_in[`ISSQ_OP_IDLE_BIT-1:0]};
  assign qs_cond_nxt = {1'b0, meas_param_ignored, 5'h00, cal_bad_r, 3'h0,
                        tc_ref_invalid, 4'h0};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_cond_r <= 16'h0000;
      ms_cond_r <= 16'h0000;
      qs_cond_r <= 16'h0000;
    end else begin
      op_cond_r <= op_cond_nxt;
      ms_cond_r <= ms_cond_in;
      qs_cond_r <= qs_cond_nxt;
    end
  end

  // Events latch on the rising edge of each condition bit
  wire [15:0] op_rise = op_cond_nxt & ~op_cond_r;
  wire [15:0] ms_rise = ms_cond_in & ~ms_cond_r;
  wire [15:0] qs_rise = qs_cond_nxt & ~qs_cond_r;

  assign err_led = |qs_cond_r;

  //////////////////////////////////////////////////////////////////////////////
  // Event register sets
  wire [7:0]  std_evt;
  wire [15:0] op_evt;
  wire [15:0] ms_evt;
  wire [15:0] qs_evt;

  issq_evt_set #(.W(8)) u_std (
    .clk      (clk),
    .rst_n    (rst_n),
    .set_bits (std_evt_set),
    .rd_clr   (rd_std),
    .cls      (is_cls),
    .ena      (std_ena_r),
    .evt_r    (std_evt),
    .summary  (std_summary)
  );

  issq_evt_set #(.W(16)) u_op (
    .clk      (clk),
    .rst_n    (rst_n),
    .set_bits (op_rise),
    .rd_clr   (rd_op),
    .cls      (is_cls),
    .ena      (op_ena_r),
    .evt_r    (op_evt),
    .summary  (op_summary)
  );

  issq_evt_set #(.W(16)) u_ms (
    .clk      (clk),
    .rst_n    (rst_n),
    .set_bits (ms_rise),
    .rd_clr   (rd_ms),
    .cls      (is_cls),
    .ena      (ms_ena_r),
    .evt_r    (ms_evt),
    .summary  (ms_summary)
  );

  issq_evt_set #(.W(16)) u_qs (
    .clk      (clk),
    .rst_n    (rst_n),
    .set_bits (qs_rise),
    .rd_clr   (rd_qs),
    .cls      (is_cls),
    .ena      (qs_ena_r),
    .evt_r    (qs_evt),
    .summary  (qs_summary)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Error code filter: default mode, enabled ranges, disabled ranges
  reg                        flt_dflt_r;
  reg [`ISSQ_FLT_IDX_W-1:0]  ena_cnt_r;
  reg [`ISSQ_FLT_IDX_W-1:0]  dis_cnt_r;
  reg signed [15:0]          ena_lo_r [0:`ISSQ_FLT_SLOTS-1];
  reg signed [15:0]          ena_hi_r [0:`ISSQ_FLT_SLOTS-1];
  reg signed [15:0]          dis_lo_r [0:`ISSQ_FLT_SLOTS-1];
  reg signed [15:0]          dis_hi_r [0:`ISSQ_FLT_SLOTS-1];
  reg                        in_ena;
  reg                        in_dis;
  integer                    i;
  integer                    i_cmb;
  integer                    i_eq;
  integer                    i_oq;

  wire signed [15:0] arg_a  = cmd_data;
  wire signed [15:0] arg_b  = cmd_data_hi;
  wire signed [15:0] rng_lo = (arg_a < arg_b) ? arg_a : arg_b;
  wire signed [15:0] rng_hi = (arg_a < arg_b) ? arg_b : arg_a;
  wire signed [15:0] code_s = err_code;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_dflt_r <= 1'b1;
      ena_cnt_r  <= {`ISSQ_FLT_IDX_W{1'b0}};
      dis_cnt_r  <= {`ISSQ_FLT_IDX_W{1'b0}};
      for (i = 0; i < `ISSQ_FLT_SLOTS; i = i + 1) begin
        ena_lo_r[i] <= 16'h0000;
        ena_hi_r[i] <= 16'h0000;
        dis_lo_r[i] <= 16'h0000;
        dis_hi_r[i] <= 16'h0000;
      end
    end else if (cmd_go) begin
      case (cmd_code)
        `ISSQ_CMD_FLT_ENA_NEW: begin
          flt_dflt_r <= 1'b0;
          ena_cnt_r  <= {`ISSQ_FLT_IDX_W{1'b0}};
          dis_cnt_r  <= {`ISSQ_FLT_IDX_W{1'b0}};
        end
        `ISSQ_CMD_FLT_ENA_ADD: begin
          if (ena_cnt_r < `ISSQ_FLT_SLOTS) begin
            ena_lo_r[ena_cnt_r[1:0]] <= rng_lo;
            ena_hi_r[ena_cnt_r[1:0]] <= rng_hi;
            ena_cnt_r <= ena_cnt_r + 3'h1;
          end
        end
        `ISSQ_CMD_FLT_DIS_ADD: begin
          if (dis_cnt_r < `ISSQ_FLT_SLOTS) begin
            dis_lo_r[dis_cnt_r[1:0]] <= rng_lo;
            dis_hi_r[dis_cnt_r[1:0]] <= rng_hi;
            dis_cnt_r <= dis_cnt_r + 3'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always @* begin
    in_ena = flt_dflt_r & ~err_is_status;
    in_dis = 1'b0;
    for (i_cmb = 0; i_cmb < `ISSQ_FLT_SLOTS; i_cmb = i_cmb + 1) begin
      if ((i_cmb < ena_cnt_r) && (code_s >= ena_lo_r[i_cmb]) &&
          (code_s <= ena_hi_r[i_cmb])) begin
        in_ena = 1'b1;
      end
      if ((i_cmb < dis_cnt_r) && (code_s >= dis_lo_r[i_cmb]) &&
          (code_s <= dis_hi_r[i_cmb])) begin
        in_dis = 1'b1;
      end
    end
  end

  wire eq_admit = err_push & in_ena & ~in_dis;

  //////////////////////////////////////////////////////////////////////////////
  // Error queue: entry 0 is the oldest
  reg [15:0]              eq_mem_r [0:`ISSQ_EQ_DEPTH-1];
  reg [`ISSQ_EQ_CNT_W-1:0] eq_cnt_r;
  reg [`ISSQ_EQ_CNT_W-1:0] eq_base;
  reg [15:0]              eq_word;
  wire                    eq_empty = (eq_cnt_r == 4'h0);
  wire                    eq_pop   = is_eqnext & ~eq_empty;
  wire [15:0]             eq_head  = eq_empty ? `ISSQ_EQ_EMPTY_CODE : eq_mem_r[0];

  always @* begin
    eq_base = eq_pop ? eq_cnt_r - 4'h1 : eq_cnt_r;
    eq_word = (eq_base == `ISSQ_EQ_DEPTH - 1) ? `ISSQ_EQ_OVF_CODE : err_code;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_cnt_r <= 4'h0;
      for (i_eq = 0; i_eq < `ISSQ_EQ_DEPTH; i_eq = i_eq + 1) begin
        eq_mem_r[i_eq] <= 16'h0000;
      end
    end else if (is_cls || is_eqclr) begin
      eq_cnt_r <= 4'h0;
    end else begin
      if (eq_pop) begin
        for (i_eq = 0; i_eq < `ISSQ_EQ_DEPTH - 1; i_eq = i_eq + 1) begin
          eq_mem_r[i_eq] <= eq_mem_r[i_eq+1];
        end
      end
      if (eq_admit && (eq_base < `ISSQ_EQ_DEPTH)) begin
        eq_mem_r[eq_base] <= eq_word;
      end
      eq_cnt_r <= eq_base + ((eq_admit && (eq_base < `ISSQ_EQ_DEPTH)) ? 4'h1 : 4'h0);
    end
  end

  assign eav = ~eq_empty;

  //////////////////////////////////////////////////////////////////////////////
  // Query answer select
  reg        ans_go;
  reg [15:0] ans_word;

  always @* begin
    ans_go   = cmd_go;
    ans_word = 16'h0000;
    case (cmd_code)
      `ISSQ_CMD_STD_EVT_RD: ans_word = {8'h00, std_evt};
      `ISSQ_CMD_STD_ENA_RD: ans_word = {8'h00, std_ena_r};
      `ISSQ_CMD_OP_COND_RD: ans_word = op_cond_r;
      `ISSQ_CMD_OP_EVT_RD:  ans_word = op_evt;
      `ISSQ_CMD_OP_ENA_RD:  ans_word = op_ena_r;
      `ISSQ_CMD_MS_COND_RD: ans_word = ms_cond_r;
      `ISSQ_CMD_MS_EVT_RD:  ans_word = ms_evt;
      `ISSQ_CMD_MS_ENA_RD:  ans_word = ms_ena_r;
      `ISSQ_CMD_QS_COND_RD: ans_word = qs_cond_r & `ISSQ_QS_USED_MASK;
      `ISSQ_CMD_QS_EVT_RD:  ans_word = qs_evt & `ISSQ_QS_USED_MASK;
      `ISSQ_CMD_QS_ENA_RD:  ans_word = qs_ena_r;
      `ISSQ_CMD_EQ_NEXT:    ans_word = eq_head;
      default:              ans_go   = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output queue
  reg [15:0]              oq_mem_r [0:`ISSQ_OQ_DEPTH-1];
  reg [`ISSQ_OQ_CNT_W-1:0] oq_cnt_r;
  reg [`ISSQ_OQ_CNT_W-1:0] oq_base;
  wire                    oq_empty = (oq_cnt_r == 3'h0);
  wire                    oq_pop   = talk & ~oq_empty;

  assign oq_full = (oq_cnt_r == `ISSQ_OQ_DEPTH);

  always @* begin
    oq_base = oq_pop ? oq_cnt_r - 3'h1 : oq_cnt_r;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oq_cnt_r     <= 3'h0;
      talk_data_r  <= 16'h0000;
      talk_valid_r <= 1'b0;
      for (i_oq = 0; i_oq < `ISSQ_OQ_DEPTH; i_oq = i_oq + 1) begin
        oq_mem_r[i_oq] <= 16'h0000;
      end
    end else begin
      talk_valid_r <= oq_pop;
      if (oq_pop) begin
        talk_data_r <= oq_mem_r[0];
        for (i_oq = 0; i_oq < `ISSQ_OQ_DEPTH - 1; i_oq = i_oq + 1) begin
          oq_mem_r[i_oq] <= oq_mem_r[i_oq+1];
        end
      end
      if (ans_go) begin
        oq_mem_r[oq_base[1:0]] <= ans_word;
      end
      oq_cnt_r <= oq_base + (ans_go ? 3'h1 : 3'h0);
    end
  end

  assign mav = ~oq_empty;

endmodule // issq_status

/* File: issq_host.sv */
// Host model for the status block: issues commands and addresses it to talk.
// Assumes the bench calls these tasks at a falling edge; signals change there.
`timescale 1ns/1ns
`include "issq_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module issq_host (
  input  wire        clk,
  input  wire        cmd_ready,
  input  wire        talk_valid_r,
  input  wire [15:0] talk_data_r,
  output reg         cmd_valid,
  output reg  [4:0]  cmd_code,
  output reg  [15:0] cmd_data,
  output reg  [15:0] cmd_data_hi,
  output reg         talk
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 5'h1f;
    cmd_data = 16'h0000;
    cmd_data_hi = 16'h0000;
    talk = 1'b0;
  end
  // Command held until an edge with ready high; data inverted once released
  task send(input [4:0] code, input [15:0] a, input [15:0] b);
    begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_data = a;
      cmd_data_hi = b;
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_data = ~cmd_data;
      cmd_data_hi = ~cmd_data_hi;
    end
  endtask
  task fetch(output [15:0] d, output ok);
    begin
      @(negedge clk);
      talk = 1'b1;
      @(negedge clk);
      talk = 1'b0;
      ok = talk_valid_r;
      d = talk_data_r;
    end
  endtask
  task query(input [4:0] code, output [15:0] d);
    reg ok;
    begin
      send(code, 16'h0000, 16'h0000);
      fetch(d, ok);
      if (ok !== 1'b1) d = 16'hxxxx;
    end
  endtask
endmodule // issq_host

/* File: issq_status_checker.sv */
// Checker for the status block, watching the top module's ports only.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`include "issq_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module issq_status_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       cmd_valid,
  input wire       cmd_ready,
  input wire [4:0] cmd_code,
  input wire       talk,
  input wire       talk_valid_r,
  input wire [7:0] std_evt_set,
  input wire       tc_ref_invalid,
  input wire       cal_const_bad,
  input wire       cal_success,
  input wire       meas_param_ignored,
  input wire       err_push,
  input wire       std_summary,
  input wire       op_summary,
  input wire       ms_summary,
  input wire       qs_summary,
  input wire       mav,
  input wire       eav,
  input wire       err_led,
  input wire       use_default_cal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take(c);
    cmd_valid && cmd_ready && cmd_code == c;
  endsequence
  sequence s_query;
    cmd_valid && cmd_ready && ((cmd_code <= 5'h0e && cmd_code[1:0] != 2'b01)
      || cmd_code == `ISSQ_CMD_EQ_NEXT);
  endsequence
  sequence s_quiet;
    !tc_ref_invalid && !meas_param_ignored && !cal_const_bad && !use_default_cal;
  endsequence
  mav_query_a: assert property (s_query |=> mav)
    else $error("message flag low after a query");
  talk_empty_a: assert property (talk && !mav |=> !talk_valid_r)
    else $error("answer from an empty output queue");
  talk_pop_a: assert property (talk && mav |=> talk_valid_r)
    else $error("no answer from a filled output queue");
  led_on_a: assert property (tc_ref_invalid || meas_param_ignored |=> err_led)
    else $error("error indicator dark with a questionable condition");
  led_off_a: assert property (s_quiet [*3] |-> !err_led)
    else $error("error indicator lit with no questionable condition");
  cal_set_a: assert property (cal_const_bad |=> use_default_cal)
    else $error("default constant not taken on bad constant");
  cal_clr_a: assert property (cal_success && !cal_const_bad |=> !use_default_cal)
    else $error("default constant kept after calibration");
  cal_hold_a: assert property (!cal_success && !cal_const_bad |=> $stable(use_default_cal))
    else $error("calibration flag moved without cause");
  preset_sum_a: assert property (s_take(`ISSQ_CMD_PRESET) |=>
    !std_summary && !op_summary && !ms_summary && !qs_summary)
    else $error("summary high after preset");
  cls_std_a: assert property (s_take(`ISSQ_CMD_CLS) ##0 std_evt_set == 8'h00
    |=> !std_summary)
    else $error("standard summary high after clear status");
  cls_eq_a: assert property (s_take(`ISSQ_CMD_CLS) ##0 !err_push |=> !eav)
    else $error("error queue not empty after clear status");
  clr_eq_a: assert property (s_take(`ISSQ_CMD_EQ_CLEAR) ##0 !err_push |=> !eav)
    else $error("error queue not empty after queue clear");
endmodule // issq_status_checker

bind issq_status issq_status_checker u_chk (.clk(clk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code), .talk(talk),
  .talk_valid_r(talk_valid_r), .std_evt_set(std_evt_set),
  .tc_ref_invalid(tc_ref_invalid), .cal_const_bad(cal_const_bad),
  .cal_success(cal_success), .meas_param_ignored(meas_param_ignored),
  .err_push(err_push), .std_summary(std_summary), .op_summary(op_summary),
  .ms_summary(ms_summary), .qs_summary(qs_summary), .mav(mav), .eav(eav),
  .err_led(err_led), .use_default_cal(use_default_cal));

/* File: issq_status_tb.sv */
// Self-checking bench for the status block, host model on the command port.
// Assumes inputs change at falling edges of a 10 MHz clock.
`timescale 1ns/1ns
`include "issq_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module issq_status_tb;
  reg clk, rst_n, instr_idle, tc_ref_invalid, cal_const_bad, cal_success;
  reg meas_param_ignored, err_push, err_is_status, ok;
  reg [7:0] std_evt_set;
  reg [15:0] op_cond_in, ms_cond_in, err_code, d;
  wire cmd_valid, cmd_ready, talk, talk_valid_r, std_summary, op_summary;
  wire ms_summary, qs_summary, mav, eav, err_led, use_default_cal;
  wire [4:0] cmd_code;
  wire [15:0] cmd_data, cmd_data_hi, talk_data_r;
  integer error_cnt, total_checks, i;
  issq_host u_host (.clk(clk), .cmd_ready(cmd_ready), .talk_valid_r(talk_valid_r),
    .talk_data_r(talk_data_r), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_data_hi(cmd_data_hi), .talk(talk));
  issq_status u_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .cmd_data_hi(cmd_data_hi), .talk(talk), .talk_data_r(talk_data_r),
    .talk_valid_r(talk_valid_r), .std_evt_set(std_evt_set), .op_cond_in(op_cond_in),
    .instr_idle(instr_idle), .ms_cond_in(ms_cond_in), .tc_ref_invalid(tc_ref_invalid),
    .cal_const_bad(cal_const_bad), .cal_success(cal_success),
    .meas_param_ignored(meas_param_ignored), .err_push(err_push), .err_code(err_code),
    .err_is_status(err_is_status), .std_summary(std_summary), .op_summary(op_summary),
    .ms_summary(ms_summary), .qs_summary(qs_summary), .mav(mav), .eav(eav),
    .err_led(err_led), .use_default_cal(use_default_cal));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    begin
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task q(input [4:0] code, input [15:0] exp);
    begin
      u_host.query(code, d);
      chk16(d, exp);
    end
  endtask
  task push(input [15:0] c, input s);
    begin
      err_code = c;
      err_is_status = s;
      err_push = 1'b1;
      step(1);
      err_push = 1'b0;
      step(1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (i = 0; i < 4; i = i + 1) begin
      q(4 * i + 2, 16'h0000);
      q(4 * i, 16'h0000);
    end
  endtask
  task t_enables;
    begin
      u_host.send(`ISSQ_CMD_STD_ENA_WR, 16'h00ff, 16'h0000);
      u_host.send(`ISSQ_CMD_OP_ENA_WR, 16'hffff, 16'h0000);
      u_host.send(`ISSQ_CMD_MS_ENA_WR, 16'h8001, 16'h0000);
      u_host.send(`ISSQ_CMD_QS_ENA_WR, 16'hffff, 16'h0000);
      q(`ISSQ_CMD_STD_ENA_RD, 16'h00ff);
      q(`ISSQ_CMD_MS_ENA_RD, 16'h8001);
      q(`ISSQ_CMD_QS_ENA_RD, 16'h4110);
      u_host.send(`ISSQ_CMD_CLS, 16'h0000, 16'h0000);
      q(`ISSQ_CMD_OP_ENA_RD, 16'hffff);
      u_host.send(`ISSQ_CMD_PRESET, 16'h0000, 16'h0000);
      for (i = 0; i < 4; i = i + 1) q(4 * i + 2, 16'h0000);
    end
  endtask
  task t_qs;
    begin
      u_host.send(`ISSQ_CMD_QS_ENA_WR, 16'h0010, 16'h0000);
      tc_ref_invalid = 1'b1;
      meas_param_ignored = 1'b1;
      step(3);
      chk1(err_led, 1'b1);
      chk1(qs_summary, 1'b1);
      q(`ISSQ_CMD_QS_COND_RD, 16'h4010);
      tc_ref_invalid = 1'b0;
      meas_param_ignored = 1'b0;
      step(3);
      chk1(err_led, 1'b0);
      q(`ISSQ_CMD_QS_EVT_RD, 16'h4010);
      q(`ISSQ_CMD_QS_EVT_RD, 16'h0000);
      chk1(qs_summary, 1'b0);
    end
  endtask
  task t_cal;
    begin
      cal_const_bad = 1'b1;
      step(1);
      cal_const_bad = 1'b0;
      step(2);
      chk1(use_default_cal, 1'b1);
      q(`ISSQ_CMD_QS_COND_RD, 16'h0100);
      cal_success = 1'b1;
      step(1);
      cal_success = 1'b0;
      step(2);
      q(`ISSQ_CMD_QS_COND_RD, 16'h0000);
      q(`ISSQ_CMD_QS_EVT_RD, 16'h0100);
    end
  endtask
  task t_cond;
    begin
      op_cond_in = 16'h0411;
      ms_cond_in = 16'h0200;
      u_host.send(`ISSQ_CMD_MS_ENA_WR, 16'h0200, 16'h0000);
      q(`ISSQ_CMD_OP_COND_RD, 16'h0011);
      chk1(ms_summary, 1'b1);
      u_host.send(`ISSQ_CMD_OP_ENA_WR, 16'h0001, 16'h0000);
      chk1(op_summary, 1'b1);
      instr_idle = 1'b1;
      step(2);
      q(`ISSQ_CMD_OP_COND_RD, 16'h0411);
      instr_idle = 1'b0;
      step(2);
      q(`ISSQ_CMD_OP_COND_RD, 16'h0011);
      q(`ISSQ_CMD_OP_EVT_RD, 16'h0411);
      chk1(op_summary, 1'b0);
      q(`ISSQ_CMD_MS_COND_RD, 16'h0200);
      op_cond_in = 16'h0000;
      ms_cond_in = 16'h0000;
    end
  endtask
  task t_std_cls;
    begin
      u_host.send(`ISSQ_CMD_STD_ENA_WR, 16'h0001, 16'h0000);
      std_evt_set = 8'h81;
      step(1);
      std_evt_set = 8'h00;
      step(1);
      chk1(std_summary, 1'b1);
      push(16'hfffb, 1'b0);
      chk1(eav, 1'b1);
      u_host.send(`ISSQ_CMD_CLS, 16'h0000, 16'h0000);
      chk1(std_summary, 1'b0);
      chk1(ms_summary, 1'b0);
      chk1(eav, 1'b0);
      q(`ISSQ_CMD_STD_EVT_RD, 16'h0000);
    end
  endtask
  task t_oq;
    begin
      for (i = 0; i < 4; i = i + 1) u_host.send(`ISSQ_CMD_STD_ENA_RD, 16'h0000, 16'h0000);
      chk1(cmd_ready, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
        u_host.fetch(d, ok);
        chk16(d, 16'h0001);
      end
      chk1(mav, 1'b0);
      u_host.fetch(d, ok);
      chk1(ok, 1'b0);
    end
  endtask
  task t_errq;
    begin
      push(16'hfff9, 1'b0);
      u_host.send(`ISSQ_CMD_PRESET, 16'h0000, 16'h0000);
      q(`ISSQ_CMD_EQ_NEXT, 16'hfff9);
      for (i = 1; i <= 12; i = i + 1) begin
        err_code = 16'h0000 - i[15:0];
        err_push = 1'b1;
        step(1);
      end
      err_push = 1'b0;
      for (i = 1; i <= 9; i = i + 1) q(`ISSQ_CMD_EQ_NEXT, 16'h0000 - i[15:0]);
      q(`ISSQ_CMD_EQ_NEXT, 16'h015e);
      q(`ISSQ_CMD_EQ_NEXT, 16'h0000);
      chk1(eav, 1'b0);
    end
  endtask
  task t_filter;
    begin
      push(16'h0007, 1'b1);
      chk1(eav, 1'b0);
      push(16'h0204, 1'b0);
      q(`ISSQ_CMD_EQ_NEXT, 16'h0204);
      u_host.send(`ISSQ_CMD_FLT_ENA_NEW, 16'h0000, 16'h0000);
      push(16'hfffb, 1'b0);
      chk1(eav, 1'b0);
      u_host.send(`ISSQ_CMD_FLT_ENA_ADD, 16'hff92, 16'hff22);
      u_host.send(`ISSQ_CMD_FLT_DIS_ADD, 16'hff6a, 16'hff6a);
      push(16'hff6a, 1'b0);
      push(16'hff9c, 1'b0);
      push(16'hff38, 1'b1);
      push(16'hff88, 1'b0);
      q(`ISSQ_CMD_EQ_NEXT, 16'hff38);
      u_host.send(`ISSQ_CMD_EQ_CLEAR, 16'h0000, 16'h0000);
      chk1(eav, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_n, instr_idle, tc_ref_invalid, cal_const_bad, cal_success} = 6'h00;
    {meas_param_ignored, err_push, err_is_status} = 3'h0;
    std_evt_set = 8'h00;
    {op_cond_in, ms_cond_in, err_code} = 48'h0;
    error_cnt = 0;
    total_checks = 0;
    step(3);
    rst_n = 1'b1;
    t_reset;
    t_enables;
    t_qs;
    t_cal;
    t_cond;
    t_std_cls;
    t_oq;
    t_errq;
    t_filter;
    tally_and_finish;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
endmodule // issq_status_tb
